// ### hw/exec_alu.sv
// Purpose: Combinational rotate and literal-subtract datapath
// Assumes: Operands are stable for the cycle
// Notes: No state; the main module registers the results
`timescale 1ns/100ps
`include "exec_params.svh"

module exec_alu
	import exec_pkg::*;
(
	input wire op_type op,
	input wire logic [`DATA_W-1:0] fdata,
	input wire logic [`DATA_W-1:0] acc,
	input wire logic [`DATA_W-1:0] literal,
	input wire logic carry_in,
	output logic [`DATA_W-1:0] result,
	output logic carry_out,
	output logic nibble_carry_flag,
	output logic zero_out
);

	// Nine-bit difference keeps the borrow
	logic [`DATA_W:0] diff;
	// Five-bit low-nibble difference
	logic [`NIB_HI+1:0] ndiff;

	// ----------------------------------------
	// Datapath select
	// ----------------------------------------
	// One process for all operation results, flags follow the operation
	always_comb
	begin
		diff = {1'b0, literal} - {1'b0, acc};
		ndiff = {1'b0, literal[`NIB_HI:0]} - {1'b0, acc[`NIB_HI:0]};
		result = fdata;
		carry_out = carry_in;
		nibble_carry_flag = 1'b0;
		unique case (op)
			rotate_left_carry_op:
			begin
				// Old carry into bit 0, bit 7 out
				result = {fdata[`MSB_POS-1:0], carry_in};
				carry_out = fdata[`MSB_POS];
			end
			rotate_right_carry_op:
			begin
				// Old carry into bit 7, bit 0 out
				result = {carry_in, fdata[`MSB_POS:`LSB_POS+1]};
				carry_out = fdata[`LSB_POS];
			end
			literal_minus_acc_op:
			begin
				// Two's complement k minus acc; no borrow means acc <= k
				result = diff[`DATA_W-1:0];
				carry_out = ~diff[`DATA_W];
				nibble_carry_flag = ~ndiff[`NIB_HI+1];
			end
			default:
			begin
				// Other operations pass the file value through
				result = fdata;
			end
		endcase
		// Zero test on the 8-bit result
		zero_out = (result == `BYTE_ZERO);
	end

endmodule

// ### hw/exec_core.sv
// Purpose: Executes return, rotate, sleep and literal subtract
// Assumes: Decode presents op with start for one cycle while ready
// Notes: Sleep gates the instruction cycle until wake arrives
`timescale 1ns/100ps
`include "exec_params.svh"

module exec_core
	import exec_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic start,
	input wire op_type op,
	input wire logic [`FADDR_W-1:0] faddr,
	input wire logic dest,
	input wire logic [`DATA_W-1:0] literal,
	input wire logic [`DATA_W-1:0] fdata,
	input wire logic push,
	input wire logic [`PC_W-1:0] push_pc,
	input wire logic wake,
	input wire logic wdt_tick,
	output logic ready,
	output logic [`PC_W-1:0] pc_reg,
	output logic [`DATA_W-1:0] acc_reg,
	output logic carry_reg,
	output logic nibble_carry_reg,
	output logic zero_reg,
	output logic timeout_status_bit,
	output logic powerdown_status_bit,
	output logic [`WDT_W-1:0] watchdog_counter,
	output logic [`PRESC_W-1:0] presc_reg,
	output logic file_we_reg,
	output logic [`FADDR_W-1:0] file_addr_reg,
	output logic [`DATA_W-1:0] file_wdata_reg,
	output logic clock_halted,
	output logic [`PC_W-1:0] stack_top_entry
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	// Sequencer state and next
	state_type state_reg;
	state_type state_next;
	// Return stack storage
	logic [`PC_W-1:0] stack_mem [`STACK_DEPTH];
	// Stack pointer, points at next free slot
	logic [`SP_W-1:0] sp_reg;
	// Index of the top entry
	logic [`SP_W-1:0] top_idx;
	// Accepted instruction this cycle
	logic go;
	// Datapath results
	logic [`DATA_W-1:0] alu_result;
	logic alu_carry;
	logic alu_nc;
	logic alu_zero;
	// Rotate decode
	logic is_rotate;

	assign go = start & ready;
	assign is_rotate = (op == rotate_left_carry_op) | (op == rotate_right_carry_op);
	assign top_idx = sp_reg - `SP_ONE;
	assign stack_top_entry = stack_mem[top_idx];

	// Instruction cycles only in the run state
	assign ready = (state_reg == st_run);
	assign clock_halted = (state_reg == st_asleep);

	// ----------------------------------------
	// Datapath
	// ----------------------------------------
	exec_alu alu_inst
	(
		.op(op),
		.fdata(fdata),
		.acc(acc_reg),
		.literal(literal),
		.carry_in(carry_reg),
		.result(alu_result),
		.carry_out(alu_carry),
		.nibble_carry_flag(alu_nc),
		.zero_out(alu_zero)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// Next-state choice
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			st_run:
			begin
				if (go && op == op_return)
					state_next = st_ret2; // Second cycle of return
				else if (go && op == op_sleep)
					state_next = st_asleep; // Halt the oscillator
			end
			st_ret2:
				state_next = st_run;
			st_asleep:
			begin
				// Only a wake-up restarts cycles
				if (wake)
					state_next = st_run;
			end
			default:
				state_next = st_run;
		endcase
	end

	// State register
	always_ff @(posedge mclk)
	begin
		if (rst)
			state_reg <= st_run;
		else
			state_reg <= state_next;
	end

	// ----------------------------------------
	// Return stack and program counter
	// ----------------------------------------
	// Push from call logic, pop on return; wraps like a ring
	always_ff @(posedge mclk)
	begin
		if (rst)
			sp_reg <= `SP_ZERO;
		else if (go && op == op_return)
			sp_reg <= top_idx; // Pop
		else if (push && ready)
			sp_reg <= sp_reg + `SP_ONE;
	end

	// Stack storage has no reset; contents are don't-care until pushed
	always_ff @(posedge mclk)
	begin
		if (push && ready && !(go && op == op_return))
			stack_mem[sp_reg] <= push_pc;
	end

	// PC loads the popped top; flags are not touched here
	always_ff @(posedge mclk)
	begin
		if (rst)
			pc_reg <= `PC_ZERO;
		else if (go && op == op_return)
			pc_reg <= stack_top_entry;
		else if (go && op != op_sleep)
			pc_reg <= pc_reg + `PC_STEP; // One word per instruction
	end

	// ----------------------------------------
	// Working register and file write
	// ----------------------------------------
	// Acc written by subtract or rotate with dest 0
	always_ff @(posedge mclk)
	begin
		if (rst)
			acc_reg <= `BYTE_ZERO;
		else if (go && op == literal_minus_acc_op)
			acc_reg <= alu_result;
		else if (go && is_rotate && dest == `DEST_ACC)
			acc_reg <= alu_result; // Single-cycle rotate
	end

	// File write-back strobe, one cycle, for dest 1
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			file_we_reg <= 1'b0;
			file_addr_reg <= {`FADDR_W{1'b0}};
			file_wdata_reg <= `BYTE_ZERO;
		end
		else
		begin
			file_we_reg <= go & is_rotate & (dest == `DEST_FILE);
			if (go && is_rotate)
			begin
				file_addr_reg <= faddr;
				file_wdata_reg <= alu_result;
			end
		end
	end

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	// Rotates touch carry only; subtract updates C, DC, Z
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			carry_reg <= 1'b0;
			nibble_carry_reg <= 1'b0;
			zero_reg <= 1'b0;
		end
		else if (go && is_rotate)
			carry_reg <= alu_carry;
		else if (go && op == literal_minus_acc_op)
		begin
			carry_reg <= alu_carry;
			nibble_carry_reg <= alu_nc;
			zero_reg <= alu_zero;
		end
	end

	// Power status bits change only on reset and sleep
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			timeout_status_bit <= `RESET_TO;
			powerdown_status_bit <= `RESET_PD;
		end
		else if (go && op == op_sleep)
		begin
			timeout_status_bit <= 1'b1;
			powerdown_status_bit <= 1'b0;
		end
	end

	// ----------------------------------------
	// Watchdog counter and prescaler
	// ----------------------------------------
	// Sleep clears both; otherwise a tick advances the chain
	always_ff @(posedge mclk)
	begin
		if (rst || (go && op == op_sleep))
		begin
			watchdog_counter <= `BYTE_ZERO;
			presc_reg <= `BYTE_ZERO;
		end
		else if (wdt_tick)
		begin
			presc_reg <= presc_reg + `BYTE_ONE;
			if (presc_reg == `BYTE_FULL)
				watchdog_counter <= watchdog_counter + `BYTE_ONE;
		end
	end

endmodule

// ### inc/exec_params.svh
// Purpose: Constants for the return/rotate/sleep/subtract execution block
// Assumes: 8-bit data path, 13-bit program counter, 8-deep return stack
// Notes: Header holds definitions only
`ifndef EXEC_PARAMS_SVH
`define EXEC_PARAMS_SVH

// ----------------------------------------
// Widths and positions
// ----------------------------------------
`define DATA_W 8
`define PC_W 13
`define FADDR_W 7
`define STACK_DEPTH 8
`define SP_W 3
`define WDT_W 8
`define PRESC_W 8
`define MSB_POS 7
`define LSB_POS 0
`define NIB_HI 3

// ----------------------------------------
// Constant values
// ----------------------------------------
`define BYTE_ZERO 8'h00
`define PC_ZERO 13'h0000
`define SP_ZERO 3'h0
`define SP_ONE 3'h1
`define PC_STEP 13'h0001
`define BYTE_ONE 8'h01
`define BYTE_FULL 8'hFF
`define DEST_ACC 1'h0
`define DEST_FILE 1'h1
`define RESET_TO 1'h1
`define RESET_PD 1'h1

`endif

// ### inc/exec_pkg.sv
// Purpose: Types shared by the execution block
// Assumes: Opcode decode happens outside the block
// Notes: Codes are binary and written out
package exec_pkg;

	// ----------------------------------------
	// Operation select
	// ----------------------------------------
	typedef enum logic [2:0]
	{
		op_none = 3'b000,
		op_return = 3'b001,
		rotate_left_carry_op = 3'b010,
		rotate_right_carry_op = 3'b011,
		op_sleep = 3'b100,
		literal_minus_acc_op = 3'b101
	} op_type;

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [1:0]
	{
		st_run = 2'b00,
		st_ret2 = 2'b01,
		st_asleep = 2'b10
	} state_type;

endpackage

// ### tb/exec_core_sva.sv
// Purpose: Port-level assertions for exec_core
// Assumes: One clock domain, synchronous reset
// Notes: Bound into exec_core after the module
`timescale 1ns/100ps

module exec_core_chk
	import exec_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic start,
	input wire op_type op,
	input wire logic dest,
	input wire logic [7:0] literal,
	input wire logic [7:0] fdata,
	input wire logic ready,
	input wire logic [12:0] pc_reg,
	input wire logic [7:0] acc_reg,
	input wire logic carry_reg,
	input wire logic zero_reg,
	input wire logic timeout_status_bit,
	input wire logic powerdown_status_bit,
	input wire logic [7:0] watchdog_counter,
	input wire logic [7:0] presc_reg,
	input wire logic file_we_reg,
	input wire logic [7:0] file_wdata_reg,
	input wire logic clock_halted,
	input wire logic [12:0] stack_top_entry
);
	// ----------------------------------------
	// Accepted requests
	// ----------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	wire ret_go = start && ready && op == op_return; // Return taken
	wire rl_go = start && ready && op == rotate_left_carry_op; // Left rotate taken
	wire rr_go = start && ready && op == rotate_right_carry_op; // Right rotate taken
	wire slp_go = start && ready && op == op_sleep; // Sleep taken
	wire sub_go = start && ready && op == literal_minus_acc_op; // Subtract taken

	ret_load_a: assert property (ret_go |=>
		pc_reg == $past(stack_top_entry) && !ready ##1 ready) else $error("return load wrong");
	ret_flag_a: assert property (ret_go |=>
		$stable(carry_reg) && $stable(zero_reg)) else $error("return changed flags");
	rl_carry_a: assert property (rl_go |=>
		carry_reg == $past(fdata[7]) && ready) else $error("left rotate carry wrong");
	rr_carry_a: assert property (rr_go |=>
		carry_reg == $past(fdata[0])) else $error("right rotate carry wrong");
	rl_file_a: assert property (rl_go && dest |=> file_we_reg &&
		file_wdata_reg == {$past(fdata[6:0]), $past(carry_reg)}) else $error("left to file wrong");
	rr_acc_a: assert property (rr_go && !dest |=> !file_we_reg &&
		acc_reg == {$past(carry_reg), $past(fdata[7:1])}) else $error("right to acc wrong");
	sleep_stat_a: assert property (slp_go |=> timeout_status_bit &&
		!powerdown_status_bit && watchdog_counter == 8'h00 && presc_reg == 8'h00
		&& $stable(carry_reg)) else $error("sleep status wrong");
	sleep_halt_a: assert property (slp_go |=> clock_halted && !ready)
		else $error("sleep did not halt");
	sub_res_a: assert property (sub_go |=> acc_reg == $past(literal) - $past(acc_reg)
		&& carry_reg == ($past(acc_reg) <= $past(literal)) && zero_reg == (acc_reg == 8'h00))
		else $error("subtract result wrong");
endmodule

bind exec_core exec_core_chk i_exec_core_chk (.*);

// ### tb/exec_core_tb.sv
// Purpose: Self-checking bench for exec_core
// Assumes: Results show one edge after a request is taken
// Notes: Driver queues expected results, a monitor pops them
`timescale 1ns/100ps

module exec_core_tb
	import exec_pkg::*;
;
	// ----------------------------------------
	// Signals and reference model
	// ----------------------------------------
	logic mclk, rst, start, dest, push, wake, wdt_tick, took;
	op_type op;
	logic [6:0] faddr, file_addr_reg;
	logic [7:0] literal, fdata, acc_reg, watchdog_counter, presc_reg, file_wdata_reg, m_acc;
	logic [12:0] push_pc, pc_reg, stack_top_entry, m_pc, pv;
	logic ready, carry_reg, nibble_carry_reg, zero_reg, timeout_status_bit;
	logic powerdown_status_bit, file_we_reg, clock_halted, m_c, m_dc, m_z;
	logic [12:0] stk[$]; // Model of the return stack
	logic [43:0] notes[$]; // Expected results, oldest first
	logic [43:0] n;
	logic [42:0] got; // Outputs gathered for one compare
	logic [31:0] seed = 32'h3;
	int bad_count, check_count, cyc;

	exec_core i_exec_core (.*);

	initial
	begin
		mclk = 0;
		forever #5 mclk = ~mclk;
	end

	function logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction

	task chk(input string s, input logic [42:0] g, input logic [42:0] e);
		check_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", s, e, g);
		end
	endtask

	task stop_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Drive one request and note what it must leave behind
	task go(input op_type o, input logic [7:0] v, input logic d);
		logic [7:0] r;
		logic w;
		logic [6:0] a;
		r = 8'h00;
		w = 0;
		start <= 1;
		op <= o;
		fdata <= v;
		literal <= v;
		dest <= d;
		a = 7'(rnd());
		faddr <= a;
		wdt_tick <= ^rnd();
		case (o)
			op_return: m_pc = stk.pop_back();
			op_sleep: ;
			literal_minus_acc_op:
			begin
				m_c = m_acc <= v;
				m_dc = m_acc[3:0] <= v[3:0];
				m_acc = v - m_acc;
				m_z = m_acc == 8'h00;
			end
			default:
			begin
				r = (o == rotate_left_carry_op) ? {v[6:0], m_c} : {m_c, v[7:1]};
				m_c = (o == rotate_left_carry_op) ? v[7] : v[0];
				w = d;
				if (!d)
					m_acc = r;
			end
		endcase
		if (o != op_return && o != op_sleep)
			m_pc = m_pc + 13'h1;
		notes.push_back({o == op_sleep, m_pc, m_acc, m_c, m_dc, m_z, w, r & {8{w}}, a & {7{w}},
			(o == op_sleep) ? 3'h5 : 3'h0});
		@(posedge mclk);
		if (o == op_return || o == op_sleep)
		begin
			start <= 0; // Dead cycle after multi-cycle ops
			@(posedge mclk);
		end
	endtask

	// Watch results one edge after each taken request
	always @(posedge mclk) took <= start && ready && !rst;
	always @(negedge mclk)
		if (took)
		begin
			n = notes.pop_front();
			got = {pc_reg, acc_reg, carry_reg, nibble_carry_reg, zero_reg, file_we_reg,
				file_we_reg ? {file_wdata_reg, file_addr_reg} : 15'h0, n[43] ? {timeout_status_bit,
				powerdown_status_bit, watchdog_counter == 8'h00 && presc_reg == 8'h00} : 3'h0};
			chk("result", got, n[42:0]);
		end

	// Hang guard
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			bad_count++;
			stop_test();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		{start, dest, push, wake, wdt_tick, m_c, m_dc, m_z} = 0;
		{faddr, literal, fdata, push_pc, m_pc, m_acc} = 0;
		op = op_none;
		rst = 1;
		repeat (2) @(posedge mclk);
		rst <= 0;
		for (int i = 0; i < 12; i++) go(literal_minus_acc_op, rnd(), 0);
		go(literal_minus_acc_op, m_acc, 0);
		$display("subtract test done");
		for (int i = 0; i < 16; i++) go(i[0] ? rotate_right_carry_op : rotate_left_carry_op, rnd(), i[1]);
		$display("rotate test done");
		start <= 0;
		for (int i = 0; i < 2; i++)
		begin
			pv = {rnd(), 5'h0} + 13'(i);
			push_pc <= pv;
			push <= 1;
			stk.push_back(pv);
			@(posedge mclk);
		end
		push <= 0;
		go(op_return, 8'h00, 0);
		go(op_return, 8'h00, 0);
		$display("return test done");
		// Long tick run so the watchdog itself has counted before sleep clears it
		wdt_tick <= 1;
		repeat (260) @(posedge mclk);
		go(op_sleep, 8'h00, 0);
		repeat (3) @(negedge mclk);
		chk("asleep", {41'h0, ready, clock_halted}, 43'h1);
		@(posedge mclk);
		wake <= 1;
		for (int i = 0; i < 8 && ready !== 1; i++) @(negedge mclk);
		chk("awake", {42'h0, ready}, 43'h1);
		@(posedge mclk);
		wake <= 0;
		go(literal_minus_acc_op, rnd(), 0);
		start <= 0;
		repeat (3) @(posedge mclk);
		$display("sleep test done");
		stop_test();
	end
endmodule
